/* File: shared/pci_addon_regs.svh */
`ifndef PCI_ADDON_REGS_SVH
`define PCI_ADDON_REGS_SVH
// Configuration offsets of the base registers (byte addresses)
`define OFS_WIN_ONE_BASE 8'h14
`define OFS_WIN_TWO_BASE 8'h18
`define OFS_INT_IO_BASE 8'h1C
`define OFS_INT_MEM_BASE 8'h20
// Field positions and hardwired values
`define WIN_BASE_LSB 21
`define WIN_PREF_VALUE 21'h00_0008
`define WIN_MASKED_LSB 21
`define WIN_MASKED_MSB 27
`define MASK_FIELD_LSB 13
`define IO_SPACE_VALUE 2'h1
`define IO_ADDR_LSB 2
`define MEM_ADDR_LSB 4
`define REG_RESET_VALUE 32'h0000_0000
`endif

/* File: shared/pci_addon_pkg.sv */
package pci_addon_pkg;
    // Kind of a PCI access seen by the decoder
    typedef enum logic [1:0] {
        ACC_CONFIG,
        ACC_MEMORY,
        ACC_IO
    } access_kind_e;
endpackage

/* File: design/pci_addon_bar_decode_irq.sv */
`timescale 1ns/1ps
`include "pci_addon_regs.svh"
// What this block does
// - Each memory-window base reads 0x8 in bits 20:0 and those bits never enter the comparison.
// - Bits 31:21 of each window base are compared with the top 11 address bits and a match claims the access.
// - Base bits 27-21 are masked by bits 19-13 of that window's own mask register before the compare.
// - Window size runs from 2 MB with no mask bits to 256 MB with all seven set.
// - A window whose base address field is all zeros is disabled and claims nothing.
// - The interrupt I/O base reads 01 in bits 1:0 to advertise I/O space.
// - Bits 31:2 of the interrupt I/O base hold the I/O address of the interrupt register.
// - The interrupt memory base reads zero in bits 3:0 to advertise memory space.
// - Bits 31:4 of the interrupt memory base give a memory address reaching the same interrupt register.
// - The interrupt register reads the INTA# pending state in bit 0 and zero above.
// - The interrupt register is decoded at the address held in the I/O base.
// - Reading the interrupt bit of the local enable register returns the pending bit.
// - Any write to bit 0 of the interrupt register negates INTA#, unless a local set arrives in the same cycle.
// - Window bases become host-writable only after configuration done and both reset to zero.
module pci_addon_bar_decode_irq #(
    parameter int MASK_BITS = 7
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register access from the PCI target engine (same clock)
    input wire logic acc_valid,
    input wire pci_addon_pkg::access_kind_e acc_kind,
    input wire logic acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [3:0] acc_byte_en,
    input wire logic [31:0] acc_wdata,
    output logic [31:0] acc_rdata_ff,
    output logic acc_claim_ff,
    // Address claim probe for target data phases
    input wire logic [31:0] probe_addr,
    output logic win_one_hit_ff,
    output logic win_two_hit_ff,
    // Mask fields of the two target address window registers
    input wire logic [MASK_BITS-1:0] win_one_mask,
    input wire logic [MASK_BITS-1:0] win_two_mask,
    // Local side controls
    input wire logic config_done,
    input wire logic local_int_set,
    output logic local_int_bit_ff,
    output logic inta_oe_ff
);
    localparam int BASE_W = 32 - `WIN_BASE_LSB;

    // Host-programmed state
    logic [BASE_W-1:0] win_base_ff [2];
    logic [31:`IO_ADDR_LSB] io_addr_ff;
    logic [31:`MEM_ADDR_LSB] mem_addr_ff;
    logic int_pending_ff;

    // Decode terms, all combinational on this clock
    logic [BASE_W-1:0] win_mask [2];
    logic [1:0] probe_hit;
    logic [31:0] win_read [2];
    logic io_hit;
    logic mem_hit;
    logic cfg_rd;
    logic cfg_wr;
    logic int_wr;

    // Next answer towards the target engine
    logic [31:0] nxt_rdata;
    logic nxt_claim;

    // Mask bit i sits over base bit 21+i; the top base bits always compare
    assign win_mask[0] = {{(BASE_W - MASK_BITS){1'b0}}, win_one_mask};
    assign win_mask[1] = {{(BASE_W - MASK_BITS){1'b0}}, win_two_mask};

    // Per-window compare; mask bits widen the window
    for (genvar w = 0; w < 2; w++) begin : g_win
        logic [BASE_W-1:0] care;
        assign care = ~win_mask[w];
        // Low 21 bits never compared, they are the fixed pref field
        assign probe_hit[w] = (win_base_ff[w] != '0) &&
            (((probe_addr[31:`WIN_BASE_LSB] ^ win_base_ff[w]) & care)
             == '0);
        assign win_read[w] = {win_base_ff[w], `WIN_PREF_VALUE};
    end

    // Interrupt register decode through both bases
    assign io_hit = acc_kind == pci_addon_pkg::ACC_IO &&
        acc_addr[31:`IO_ADDR_LSB] == io_addr_ff;
    assign mem_hit = acc_kind == pci_addon_pkg::ACC_MEMORY &&
        acc_addr[31:`MEM_ADDR_LSB] == mem_addr_ff;
    assign cfg_rd = acc_valid && !acc_write &&
        acc_kind == pci_addon_pkg::ACC_CONFIG;
    assign cfg_wr = acc_valid && acc_write &&
        acc_kind == pci_addon_pkg::ACC_CONFIG && acc_byte_en == 4'hF;
    assign int_wr = acc_valid && acc_write && acc_byte_en[0] &&
        (io_hit || mem_hit);

    // Read mux; unmapped config offsets read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_claim = 1'b0;
        if (acc_valid && (io_hit || mem_hit)) begin
            nxt_claim = 1'b1;
            if (!acc_write) begin
                nxt_rdata = {31'h0000_0000, int_pending_ff};
            end
        end else if (cfg_rd) begin
            unique case (acc_addr[7:0])
                `OFS_WIN_ONE_BASE: nxt_rdata = win_read[0];
                `OFS_WIN_TWO_BASE: nxt_rdata = win_read[1];
                `OFS_INT_IO_BASE:
                    nxt_rdata = {io_addr_ff, `IO_SPACE_VALUE};
                `OFS_INT_MEM_BASE:
                    nxt_rdata = {mem_addr_ff, 4'h0};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data, held until the next enabled edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_rdata_ff <= `REG_RESET_VALUE;
        end else if (clk_en) begin
            acc_rdata_ff <= nxt_rdata;
        end
    end

    // Claim flag; config space is answered but never claimed here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_claim_ff <= 1'b0;
        end else if (clk_en) begin
            acc_claim_ff <= nxt_claim;
        end
    end

    // Window one claim, one cycle after the probe address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_one_hit_ff <= 1'b0;
        end else if (clk_en) begin
            win_one_hit_ff <= probe_hit[0];
        end
    end

    // Window two claim, masked by its own register only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_two_hit_ff <= 1'b0;
        end else if (clk_en) begin
            win_two_hit_ff <= probe_hit[1];
        end
    end

    // Window bases locked until local configuration completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win_base_ff[0] <= '0;
            win_base_ff[1] <= '0;
        end else if (clk_en && cfg_wr && config_done) begin
            if (acc_addr[7:0] == `OFS_WIN_ONE_BASE) begin
                win_base_ff[0] <= acc_wdata[31:`WIN_BASE_LSB];
            end
            if (acc_addr[7:0] == `OFS_WIN_TWO_BASE) begin
                win_base_ff[1] <= acc_wdata[31:`WIN_BASE_LSB];
            end
        end
    end

    // Interrupt register I/O address; zero still decodes address zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            io_addr_ff <= '0;
        end else if (clk_en && cfg_wr) begin
            if (acc_addr[7:0] == `OFS_INT_IO_BASE) begin
                io_addr_ff <= acc_wdata[31:`IO_ADDR_LSB];
            end
        end
    end

    // Interrupt register memory address, a second path to the same flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_addr_ff <= '0;
        end else if (clk_en && cfg_wr) begin
            if (acc_addr[7:0] == `OFS_INT_MEM_BASE) begin
                mem_addr_ff <= acc_wdata[31:`MEM_ADDR_LSB];
            end
        end
    end

    // Pending flag: a local set in the clear cycle wins, not lost
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            int_pending_ff <= 1'b0;
        end else if (clk_en) begin
            if (local_int_set) begin
                int_pending_ff <= 1'b1;
            end else if (int_wr) begin
                int_pending_ff <= 1'b0;
            end
        end
    end

    // INTA# drive; a set bypasses the flag so the pin rises one edge sooner
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inta_oe_ff <= 1'b0;
        end else if (clk_en) begin
            inta_oe_ff <= int_pending_ff || local_int_set;
        end
    end

    // Local enable-register view of the pending flag, same timing as pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            local_int_bit_ff <= 1'b0;
        end else if (clk_en) begin
            local_int_bit_ff <= int_pending_ff || local_int_set;
        end
    end
endmodule

/* File: dv/pci_addon_checker_assertions.sv */
`timescale 1ns/1ps
`include "pci_addon_regs.svh"
module pci_addon_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic acc_valid,
    input wire pci_addon_pkg::access_kind_e acc_kind,
    input wire logic acc_write,
    input wire logic [31:0] acc_addr,
    input wire logic [3:0] acc_byte_en,
    input wire logic [31:0] acc_rdata_ff,
    input wire logic acc_claim_ff,
    input wire logic local_int_set,
    input wire logic local_int_bit_ff,
    input wire logic inta_oe_ff
);
    default clocking @(posedge sys_clk); endclocking
    // A low clock enable freezes every flop, so the checks pause with it
    default disable iff (rst || !clk_en);
    logic cfg;
    logic rd;
    logic clr;
    // Config reads decode on the low offset byte only
    assign cfg = acc_valid && acc_kind == pci_addon_pkg::ACC_CONFIG;
    assign rd = cfg && !acc_write;
    // Only a write carrying byte lane 0 clears the pending flag
    assign clr = acc_valid && acc_write && acc_byte_en[0];
    win_pref_a: assert property (
        rd && acc_addr[7:0] inside {`OFS_WIN_ONE_BASE, `OFS_WIN_TWO_BASE}
        |=> acc_rdata_ff[20:0] == `WIN_PREF_VALUE) else $error("bad pref");
    io_space_a: assert property (
        rd && acc_addr[7:0] == `OFS_INT_IO_BASE
        |=> acc_rdata_ff[1:0] == `IO_SPACE_VALUE) else $error("bad io space");
    mem_space_a: assert property (
        rd && acc_addr[7:0] == `OFS_INT_MEM_BASE
        |=> acc_rdata_ff[3:0] == 4'h0) else $error("bad mem space");
    cfg_claim_a: assert property (cfg |=> !acc_claim_ff)
        else $error("config claimed");
    irq_upper_a: assert property (
        acc_valid && !acc_write ##1 acc_claim_ff
        |-> acc_rdata_ff[31:1] == 31'h0000_0000) else $error("upper bits set");
    irq_raise_a: assert property (local_int_set |-> ##[1:2] inta_oe_ff)
        else $error("no raise");
    // The enable-register view must agree with a read of the flag
    irq_mirror_a: assert property (
        acc_valid && !acc_write && !local_int_set ##1 acc_claim_ff
        |-> acc_rdata_ff[0] == local_int_bit_ff) else $error("views differ");
    irq_clear_a: assert property (
        clr && !local_int_set ##1 acc_claim_ff && !local_int_set
        |-> ##[0:1] !inta_oe_ff) else $error("no clear");
endmodule
bind pci_addon_bar_decode_irq pci_addon_checker i_pci_addon_checker (
    .sys_clk, .rst, .clk_en, .acc_valid, .acc_kind, .acc_write, .acc_addr,
    .acc_byte_en, .acc_rdata_ff, .acc_claim_ff, .local_int_set,
    .local_int_bit_ff, .inta_oe_ff);

/* File: dv/pci_host_model.sv */
`timescale 1ns/1ps
module pci_host_model (
    input wire logic sys_clk,
    output pci_addon_pkg::access_kind_e acc_kind = pci_addon_pkg::ACC_CONFIG,
    output logic acc_valid = 1'h0,
    output logic acc_write = 1'h0,
    output logic [31:0] acc_addr = 32'h0000_0000,
    output logic [3:0] acc_byte_en = 4'hF,
    output logic [31:0] acc_wdata = 32'h0000_0000
);
    // Held to the taking edge; lines inverted after so stale data never helps
    task automatic access(input pci_addon_pkg::access_kind_e k, input logic w,
            input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        acc_valid <= 1'h1;
        acc_kind <= k;
        acc_write <= w;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge sys_clk);
        acc_valid <= 1'h0;
        acc_addr <= ~a;
        acc_wdata <= ~d;
    endtask
endmodule

/* File: dv/pci_addon_bar_decode_irq_test.sv */
`timescale 1ns/1ps
module pci_addon_bar_decode_irq_test;
    localparam pci_addon_pkg::access_kind_e C = pci_addon_pkg::ACC_CONFIG;
    localparam pci_addon_pkg::access_kind_e I = pci_addon_pkg::ACC_IO;
    localparam pci_addon_pkg::access_kind_e M = pci_addon_pkg::ACC_MEMORY;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [31:0] probe_addr = 32'h0000_0000;
    logic [6:0] win_one_mask = 7'h00;
    logic [6:0] win_two_mask = 7'h00;
    logic clk_en = 1'h1;
    logic config_done = 1'h0;
    logic local_int_set = 1'h0;
    pci_addon_pkg::access_kind_e acc_kind;
    logic acc_valid, acc_write, acc_claim_ff, hit1, hit2, int_bit, inta_oe;
    logic [3:0] acc_byte_en;
    logic [31:0] acc_addr, acc_wdata, acc_rdata_ff;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Probe table: address, masks of windows one and two, expected hits
    logic [47:0] tbl [9] = '{{32'h1240_0000, 7'h00, 7'h00, 2'h2},
        {32'h125F_FFFF, 7'h00, 7'h00, 2'h2},
        {32'h1260_0000, 7'h00, 7'h00, 2'h0},
        {32'h1260_0000, 7'h01, 7'h00, 2'h2},
        {32'h1000_0000, 7'h7F, 7'h00, 2'h2},
        {32'h1FFF_FFFF, 7'h7F, 7'h00, 2'h2},
        {32'h2010_0000, 7'h7F, 7'h00, 2'h1},
        {32'h2FE0_0000, 7'h7F, 7'h00, 2'h0},
        {32'h2FE0_0000, 7'h00, 7'h7F, 2'h1}};
    always #50 sys_clk = ~sys_clk;
    pci_host_model i_pci_host_model (.sys_clk, .acc_kind, .acc_valid,
        .acc_write, .acc_addr, .acc_byte_en, .acc_wdata);
    pci_addon_bar_decode_irq i_pci_addon_bar_decode_irq (.sys_clk, .rst,
        .clk_en, .acc_valid, .acc_kind, .acc_write, .acc_addr,
        .acc_byte_en, .acc_wdata, .acc_rdata_ff, .acc_claim_ff, .probe_addr,
        .win_one_hit_ff(hit1), .win_two_hit_ff(hit2), .win_one_mask,
        .win_two_mask, .config_done, .local_int_set,
        .local_int_bit_ff(int_bit), .inta_oe_ff(inta_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One access; read data and claim settle just after the taking edge
    task automatic go(input pci_addon_pkg::access_kind_e k, input logic w,
            input logic [31:0] a, d, r, input logic c);
        i_pci_host_model.access(k, w, a, d);
        #1;
        if (!w) check(acc_rdata_ff, r);
        check({31'h0, acc_claim_ff}, {31'h0, c});
    endtask
    task automatic probe(input logic [47:0] e);
        @(posedge sys_clk);
        probe_addr <= e[47:16];
        win_one_mask <= e[15:9];
        win_two_mask <= e[8:2];
        @(posedge sys_clk);
        #1;
        check({30'h0, hit1, hit2}, {30'h0, e[1:0]});
    endtask
    task automatic pulse_wait();
        @(posedge sys_clk);
        local_int_set <= 1'h1;
        @(posedge sys_clk);
        local_int_set <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // Hang guard, far above the roughly 90 cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        probe({32'h0000_0000, 7'h00, 7'h00, 2'h0});
        go(C, 0, 32'h14, 0, 32'h0000_0008, 0);
        go(C, 0, 32'h18, 0, 32'h0000_0008, 0);
        go(C, 0, 32'h1C, 0, 32'h0000_0001, 0);
        go(C, 1, 32'h14, 32'h124F_FFFF, 0, 0);
        go(C, 0, 32'h14, 0, 32'h0000_0008, 0);
        @(posedge sys_clk);
        config_done <= 1'h1;
        go(C, 1, 32'h14, 32'h124F_FFFF, 0, 0);
        go(C, 0, 32'h14, 0, 32'h1240_0008, 0);
        go(C, 1, 32'h18, 32'h2000_0000, 0, 0);
        go(C, 0, 32'h18, 0, 32'h2000_0008, 0);
        go(C, 1, 32'h1C, 32'h0000_0302, 0, 0);
        go(C, 0, 32'h1C, 0, 32'h0000_0301, 0);
        go(C, 1, 32'h20, 32'h8000_005F, 0, 0);
        go(C, 0, 32'h20, 0, 32'h8000_0050, 0);
        for (int i = 0; i < 9; i++) probe(tbl[i]);
        pulse_wait();
        check({30'h0, int_bit, inta_oe}, 32'h0000_0003);
        go(I, 0, 32'h0000_0300, 0, 32'h0000_0001, 1);
        go(M, 0, 32'h8000_005C, 0, 32'h0000_0001, 1);
        go(I, 1, 32'h0000_0304, 0, 0, 0);
        go(I, 1, 32'h0000_0303, 0, 0, 1);
        repeat (2) @(posedge sys_clk);
        check({31'h0, inta_oe}, 32'h0000_0000);
        go(M, 0, 32'h8000_0050, 0, 32'h0000_0000, 1);
        pulse_wait();
        go(M, 1, 32'h8000_0050, 32'h0000_0001, 0, 1);
        repeat (2) @(posedge sys_clk);
        check({31'h0, int_bit}, 32'h0000_0000);
        // A set while the clock enable is low must leave INTA# untouched
        @(posedge sys_clk);
        clk_en <= 1'h0;
        local_int_set <= 1'h1;
        @(posedge sys_clk);
        local_int_set <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({31'h0, inta_oe}, 32'h0000_0000);
        @(posedge sys_clk);
        clk_en <= 1'h1;
        go(M, 0, 32'h8000_0050, 0, 32'h0000_0000, 1);
        close_out();
    end
endmodule
